// ---- testbench/plpm_link_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Far transceiver: answers each unmuted frame after a delay
// ****
module plpm_link_partner (
  input  wire logic       clk_sys,  // Clock
  input  wire logic       rst,      // Reset
  input  wire logic       lnkSend,  // Frame in
  input  wire logic [7:0] lnkAddr,  // Frame address
  input  wire logic       mute,     // Stop answering
  input  wire logic [7:0] dly,      // Answer delay, 1 or more
  output var  logic       lnkAck,   // Answer pulse
  output var  logic [7:0] lnkRxData // Answer data
);
  logic [7:0] cnt; // Cycles to the answer
  // Acks writes, sleep requests and pings alike
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      lnkAck <= 1'b0;
      lnkRxData <= 8'h00;
    end else begin
      if (lnkSend && !mute) cnt <= dly;
      else if (cnt != 8'h00) cnt <= cnt - 8'h01;
      lnkAck <= (cnt == 8'h01);
      // Data only valid with the ack; toggles otherwise
      lnkRxData <= (cnt == 8'h01) ? lnkAddr ^ 8'h5A : ~lnkRxData;
    end
  end
endmodule // plpm_link_partner
`default_nettype wire

// ---- testbench/plpm_manager_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks
// ****
module plpm_manager_chk (
  input wire logic       clk_sys,       // Clock
  input wire logic       rst,           // Reset
  input wire logic       wb_cyc_i,      // Bus cycle
  input wire logic       wb_stb_i,      // Bus strobe
  input wire logic       wb_ack_o,      // Bus ack
  input wire logic       prtReq,        // Partner access
  input wire logic       prtWe,         // Partner write
  input wire logic [7:0] prtAddr,       // Partner address
  input wire logic       prtRdValid,    // Reply strobe
  input wire logic [7:0] prtRdData,     // Reply data
  input wire logic       scratchWrite,  // Scratch write event
  input wire logic       remotePending, // Remote busy
  input wire logic       remoteDone,    // Remote done
  input wire logic       pairUp,        // Link indicator
  input wire logic       linkRestart,   // Restart pulse
  input wire logic       analogOn,      // Analog power
  input wire logic       lpClkOn        // Low-power clock
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Partner read of a hidden place, then its dummy reply
  sequence sHiddenRd; prtReq && !prtWe && prtAddr[7]; endsequence
  sequence sDummy; prtRdValid && prtRdData == 8'hFF; endsequence
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_done_clears: assert property (
    $fell(remotePending) && !linkRestart |-> remoteDone)
    else $error("busy fell without done");
  chk_sleep_clock: assert property ($fell(analogOn) |-> !lpClkOn)
    else $error("clock kept in sleep");
  chk_sleep_paired: assert property ($fell(analogOn) |-> pairUp)
    else $error("indicator low in sleep");
  chk_restart_drop: assert property (linkRestart |-> ##[0:1] !pairUp)
    else $error("indicator high at restart");
  chk_hidden_read: assert property (sHiddenRd |=> sDummy)
    else $error("hidden register exposed");
  chk_scratch_write: assert property (
    scratchWrite |-> $past(prtReq && prtWe && prtAddr < 8'h08))
    else $error("stray scratch write event");
endmodule // plpm_manager_chk
bind plpm_manager plpm_manager_chk plpm_manager_chk_inst (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .prtReq(prtReq), .prtWe(prtWe), .prtAddr(prtAddr),
  .prtRdValid(prtRdValid), .prtRdData(prtRdData),
  .scratchWrite(scratchWrite), .remotePending(remotePending),
  .remoteDone(remoteDone), .pairUp(pairUp), .linkRestart(linkRestart),
  .analogOn(analogOn), .lpClkOn(lpClkOn));
`default_nettype wire

// ---- testbench/test_plpm_manager.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_plpm_manager;
  logic clk_sys = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 0, prtAddr = 0, prtWdata = 0, rx, a1, a2, d1;
  logic [31:0] wb_dat_i = 0, rd, wb_dat_o;
  logic [3:0] wb_sel_i = 4'hF;
  logic slpCmd = 0; // Partner's sleep order
  logic pairDone = 0, lnkLost = 0, prtReq = 0, prtWe = 0, mute = 0;
  logic tempDone = 0, compDone = 0, wb_ack_o, lnkAck, lnkSend, prtRdValid;
  logic [7:0] dly = 1, lnkRxData, lnkAddr, lnkData, prtRdData;
  logic [2:0] lnkOp;
  logic tempStart, compStart, pairUp, linkRestart, analogOn, lpClkOn;
  logic txRxEn, tunnelGo, remotePending, remoteDone, scratchRead, scratchWrite;
  logic [255:0] wrSeen = '0; // Addresses written over the link
  logic [18:0] fr[0:2];      // First frames after pairing
  int errors = 0, compares = 0, nf = 0, nScr = 0, base, nTmp = 0;
  always #5 clk_sys = ~clk_sys;
  plpm_manager #(.UNIT_CYCLES(10)) plpm_manager_inst (.clk_sys, .rst,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .pairDone, .lnkLost, .lnkAck, .lnkRxData,
    .lnkSleepCmd(slpCmd), .lnkSend, .lnkOp, .lnkAddr, .lnkData, .prtReq,
    .prtWe, .prtAddr, .prtWdata, .prtRdValid, .prtRdData, .tempStart,
    .tempDone, .compStart, .compDone, .pairUp, .linkRestart, .analogOn,
    .lpClkOn, .txRxEn, .tunnelGo, .remotePending, .remoteDone,
    .scratchRead, .scratchWrite);
  plpm_link_partner plpm_link_partner_inst (.clk_sys, .rst, .lnkSend,
    .lnkAddr, .mute, .dly, .lnkAck, .lnkRxData);
  // Echo handshakes, log frames and events
  always @(posedge clk_sys) begin
    tempDone <= tempStart;
    compDone <= compStart;
    if (lnkSend && lnkOp == 3'h1) wrSeen[lnkAddr] <= 1'b1;
    if (lnkSend && nf < 3) fr[nf] <= {lnkOp, lnkAddr, lnkData};
    if (lnkSend && nf < 3) nf <= nf + 1;
    if (scratchRead) nScr <= nScr + 1;
    if (tempStart) nTmp <= nTmp + 1;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task prt(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {prtReq, prtWe, prtAddr, prtWdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    prtReq <= 1'b0;
    @(posedge clk_sys);
    rx = prtRdData;
  endtask
  task automatic waitFor(ref logic s, input logic v);
    for (int n = 0; n < 4000 && s !== v; n++) @(posedge clk_sys);
    if (s !== v) errors++;
  endtask
  task complete_run;
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #400000;
    errors++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h0a8595e4));
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    dly <= 8'($urandom_range(1, 6));
    wb(0, 8'h08, 0);
    check(rd, 32'h0000_000B);
    wb(0, 8'h0C, 0);
    check(rd, 32'h0000_0019);
    wb(0, 8'hFC, 0);
    check(rd, 32'h0000_0000);
    wb(1, 8'h04, 32'h0001_1234);
    check(remotePending, 0);
    for (int i = 0; i < 8; i++) begin
      d1 = $urandom;
      prt(1, 8'(i), d1);
      wb(0, 8'(8'h20 + 4 * i), 0);
      check(rd, {24'h00_0000, d1});
      prt(0, 8'(i), 0);
      check(rx, d1);
    end
    @(posedge clk_sys);
    check(nScr, 8);
    prt(0, 8'h80, 0);
    check(rx, 8'hFF);
    pairDone <= 1'b1;
    @(posedge clk_sys);
    pairDone <= 1'b0;
    waitFor(pairUp, 1);
    check(pairUp, 1);
    for (int j = 0; j < 2000 && nf < 3; j++) @(posedge clk_sys);
    check(fr[0], {3'h1, 8'h10, 8'h01});
    check(fr[1], {3'h1, 8'h11, 8'h0B});
    check(fr[2][18:16], 3'h3);
    a1 = 8'($urandom_range(0, 7));
    a2 = a1 + 8'h40;
    d1 = $urandom;
    wb(1, 8'h04, {15'h0000, 1'b1, d1, a1});
    check(remotePending, 1);
    wb(1, 8'h04, {15'h0000, 1'b1, d1, a2});
    waitFor(remoteDone, 1);
    check(remotePending, 0);
    check(wrSeen[a1], 1);
    check(wrSeen[a2], 0);
    check(wrSeen[8'h34], 0);
    base = nScr;
    wb(1, 8'h04, {16'h0000, a2});
    waitFor(remoteDone, 1);
    wb(0, 8'h04, 0);
    check(rd[8:0], {1'b0, a2 ^ 8'h5A});
    check(nScr - base, 1);
    wb(1, 8'h00, 32'h0000_0003);
    wb(1, 8'h04, {16'h0000, a1});
    check(remotePending, 0);
    wb(1, 8'h00, 32'h0000_0001);
    waitFor(analogOn, 0);
    check(pairUp, 1);
    check(lpClkOn, 0);
    mute <= 1'b1;
    waitFor(analogOn, 1);
    check(txRxEn, 1);
    waitFor(linkRestart, 1);
    @(posedge clk_sys);
    check(pairUp, 0);
    // Channel lost while a frame waits for its answer
    pairDone <= 1'b1;
    @(posedge clk_sys);
    pairDone <= 1'b0;
    waitFor(lnkSend, 1);
    wb(1, 8'h04, {16'h0000, a1});
    lnkLost <= 1'b1;
    @(posedge clk_sys);
    lnkLost <= 1'b0;
    waitFor(linkRestart, 1);
    check(pairUp, 0);
    check(remotePending, 0);
    // Temperature, then tunneling, then idle with power kept
    wb(1, 8'h00, 32'h0000_0004);
    mute <= 1'b0;
    pairDone <= 1'b1;
    @(posedge clk_sys);
    pairDone <= 1'b0;
    wb(1, 8'h00, 32'h0000_0024);
    waitFor(tunnelGo, 1);
    check(nTmp, 1);
    check(remoteDone, 1);
    repeat (30) @(posedge clk_sys);
    check(analogOn, 1);
    // Remote role sleeps on the partner's order
    wb(1, 8'h00, 32'h0000_0003);
    slpCmd <= 1'b1;
    @(posedge clk_sys);
    slpCmd <= 1'b0;
    waitFor(analogOn, 0);
    check(lpClkOn, 0);
    check(pairUp, 1);
    complete_run;
  end
endmodule // test_plpm_manager
`default_nettype wire

// ---- verilog/plpm_manager.v ----
`timescale 1ns/1ps
`default_nettype none
`include "plpm_map.vh"
module plpm_manager #(
  parameter UNIT_CYCLES = `PLPM_UNIT_CYC // Cycles per 10 ms unit
) (
  input  wire        clk_sys,     // System clock, 100 MHz
  input  wire        rst,         // Async reset, high
  input  wire        wb_cyc_i,    // Wishbone cycle
  input  wire        wb_stb_i,    // Wishbone strobe
  input  wire        wb_we_i,     // Wishbone write
  input  wire [7:0]  wb_adr_i,    // Byte address
  input  wire [3:0]  wb_sel_i,    // Byte lanes
  input  wire [31:0] wb_dat_i,    // Write data
  output reg  [31:0] wb_dat_o,    // Read data
  output reg         wb_ack_o,    // Acknowledge
  input  wire        pairDone,    // Pairing search left, pulse
  input  wire        lnkLost,     // Radio channel lost, pulse
  input  wire        lnkAck,      // Partner answered, pulse
  input  wire [7:0]  lnkRxData,   // Data with the answer
  input  wire        lnkSleepCmd, // Partner asks us to sleep
  output reg         lnkSend,     // Frame out, pulse
  output reg  [2:0]  lnkOp,       // Frame opcode
  output reg  [7:0]  lnkAddr,     // Frame register address
  output reg  [7:0]  lnkData,     // Frame data byte
  input  wire        prtReq,      // Partner access, pulse
  input  wire        prtWe,       // Partner access is a write
  input  wire [7:0]  prtAddr,     // Partner access address
  input  wire [7:0]  prtWdata,    // Partner write data
  output reg         prtRdValid,  // Reply to partner read
  output reg  [7:0]  prtRdData,   // Reply data
  output reg         tempStart,   // Temperature measure, pulse
  input  wire        tempDone,    // Measure finished, pulse
  output reg         compStart,   // Power compensation, pulse
  input  wire        compDone,    // Compensation done, pulse
  output reg         pairUp,      // Pairing-up indicator
  output reg         linkRestart, // Link restart, pulse
  output reg         analogOn,    // Analog and radio powered
  output reg         lpClkOn,     // Low-power digital clock on
  output reg         txRxEn,      // Transmit/receive enabled
  output reg         tunnelGo,    // Start tunneling, pulse
  output reg         remotePending, // Remote access busy
  output reg         remoteDone,  // Remote access done, pulse
  output reg         scratchRead, // Scratch read event, pulse
  output reg         scratchWrite // Scratch write event, pulse
);
  // ***********************************************
  // States and frame phases
  // ***********************************************
  localparam [2:0] S_OFF   = 3'd0; // Not paired
  localparam [2:0] S_HOUSE = 3'd1; // Pick next task
  localparam [2:0] S_TEMP  = 3'd2; // Wait temperature
  localparam [2:0] S_COMP  = 3'd3; // Wait compensation
  localparam [2:0] S_WAIT  = 3'd4; // Wait partner answer
  localparam [2:0] S_DOZE  = 3'd5; // Sleep or idle interval
  localparam [2:0] S_WAKE  = 3'd6; // Seek partner
  localparam [2:0] P_RRA = 3'd0; // Host remote access
  localparam [2:0] P_PWR = 3'd1; // Power control copy
  localparam [2:0] P_DZ  = 3'd2; // Interval copy
  localparam [2:0] P_TUN = 3'd3; // Tunneling command
  localparam [2:0] P_SLP = 3'd4; // Sleep request
  localparam [15:0] DIV_W = 16'h0000; // Width anchor
  // ***********************************************
  // Registers
  // ***********************************************
  reg [7:0]  ctrl;        // Control bits
  reg [7:0]  dozeUnits;   // Interval, 10 ms units
  reg [7:0]  wakeUnits;   // Wake timeout, 10 ms units
  reg [7:0]  rraAddr;     // Remote access address
  reg [7:0]  rraData;     // Write data or read result
  reg        rraWr;       // Access is a write
  reg        tunPend;     // Tunneling command waiting
  reg [7:0]  scr [0:7];   // Scratch registers
  reg [2:0]  state;       // Sequencer state
  reg [2:0]  phase;       // What the awaited answer is for
  reg [3:0]  hkDone;      // Temp, comp, pwr, doze done
  reg        sleeping;    // Doze with circuits off
  reg        dozeLoad;    // Start interval timer
  reg        wakeLoad;    // Start wake timer
  reg [31:0] divCnt;      // Unit divider
  reg        unitTick;    // One pulse per unit
  wire       dozeExp;     // Interval over
  wire       wakeExp;     // Wake timeout over
  wire       wbReq;       // New bus request
  wire       isRemote;    // Configured as Remote role
  wire       rraGo;       // Host starts remote access
  wire       tunGo;       // Host sets tunneling command
  assign wbReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign isRemote = ctrl[`PLPM_CTRL_ROLE];
  // Host request accepted only when legal
  assign rraGo = wbReq & wb_we_i & (&wb_sel_i[2:0])
               & (wb_adr_i == `PLPM_OFF_RACC)
               & (state != S_OFF)
               & ~remotePending
               & ~isRemote;
  assign tunGo = wbReq & wb_we_i & wb_sel_i[0]
               & (wb_adr_i == `PLPM_OFF_CTRL)
               & wb_dat_i[`PLPM_CTRL_TUNNEL] & ~isRemote;
  // ***********************************************
  // Unit divider, one enable pulse per 10 ms
  // ***********************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      divCnt   <= 32'h0000_0000;
      unitTick <= 1'b0;
    end else if (divCnt >= UNIT_CYCLES - 1) begin
      divCnt   <= 32'h0000_0000;
      unitTick <= 1'b1;
    end else begin
      divCnt   <= divCnt + 32'h0000_0001;
      unitTick <= 1'b0;
    end
  end
  // Interval and wake-resume timers
  plpm_unit_timer uDoze (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (unitTick),
    .load    (dozeLoad),
    .period  (dozeUnits),
    .expired (dozeExp)
  );
  plpm_unit_timer uWake (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (unitTick),
    .load    (wakeLoad),
    .period  (wakeUnits),
    .expired (wakeExp)
  );
  // ***********************************************
  // Wishbone slave: ack one cycle after request
  // ***********************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      ctrl      <= `PLPM_CTRL_RST;
      dozeUnits <= `PLPM_DOZE_RST;
      wakeUnits <= `PLPM_WAKE_RST;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq && wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          // Tunnel bit is a command, not stored
          `PLPM_OFF_CTRL: ctrl <= {3'b000, wb_dat_i[4:0]};
          `PLPM_OFF_DOZE: dozeUnits <= wb_dat_i[7:0];
          `PLPM_OFF_WAKE: wakeUnits <= wb_dat_i[7:0];
          default: ;
        endcase
      end
      if (wbReq && !wb_we_i) begin
        case (wb_adr_i)
          `PLPM_OFF_CTRL: wb_dat_o <= {24'h00_0000, ctrl};
          `PLPM_OFF_RACC: wb_dat_o <= {15'h0000, rraWr,
                                       7'h00, remotePending,
                                       rraData};
          `PLPM_OFF_DOZE: wb_dat_o <= {24'h00_0000, dozeUnits};
          `PLPM_OFF_WAKE: wb_dat_o <= {24'h00_0000, wakeUnits};
          `PLPM_OFF_STAT: wb_dat_o <= {24'h00_0000, tunPend,
                                       sleeping, pairUp,
                                       remotePending, 1'b0,
                                       state};
          default: begin
            // Scratch window, else unmapped reads zero
            if (wb_adr_i[7:5] == 3'b001 && wb_adr_i[1:0] == 2'b00)
              wb_dat_o <= {24'h00_0000, scr[wb_adr_i[4:2]]};
            else
              wb_dat_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end
  // ***********************************************
  // Scratch registers, one per generate entry
  // ***********************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : gScr
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          scr[gi] <= 8'h00;
        end else if (prtReq && prtWe
                     && prtAddr == `PLPM_RA_SCR + gi) begin
          scr[gi] <= prtWdata;
        end else if (wbReq && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == `PLPM_OFF_SCR + 4 * gi) begin
          scr[gi] <= wb_dat_i[7:0];
        end
      end
    end
  endgenerate
  // ***********************************************
  // Answer partner accesses to our registers
  // ***********************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prtRdValid   <= 1'b0;
      prtRdData    <= 8'h00;
      scratchWrite <= 1'b0;
    end else begin
      prtRdValid   <= prtReq & ~prtWe;
      scratchWrite <= prtReq & prtWe & (prtAddr[7:3] == 5'h00);
      if (prtReq && !prtWe) begin
        if (prtAddr[7:3] == 5'h00)
          prtRdData <= scr[prtAddr[2:0]];
        else if (prtAddr == `PLPM_RA_PWR)
          prtRdData <= ctrl;
        else if (prtAddr == `PLPM_RA_DOZE)
          prtRdData <= dozeUnits;
        else
          // Local-only and unknown give a dummy
          prtRdData <= `PLPM_RA_POISON;
      end
    end
  end
  // ***********************************************
  // Low-power sequencer
  // ***********************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= S_OFF;
      phase <= P_RRA;
      hkDone <= 4'h0;
      sleeping <= 1'b0;
      dozeLoad <= 1'b0;
      wakeLoad <= 1'b0;
      lnkSend <= 1'b0;
      lnkOp <= 3'h0;
      lnkAddr <= 8'h00;
      lnkData <= 8'h00;
      tempStart <= 1'b0;
      compStart <= 1'b0;
      pairUp <= 1'b0;
      linkRestart <= 1'b0;
      analogOn <= 1'b1;
      lpClkOn <= 1'b1;
      txRxEn <= 1'b0;
      tunnelGo <= 1'b0;
      remotePending <= 1'b0;
      remoteDone <= 1'b0;
      scratchRead <= 1'b0;
      rraAddr <= 8'h00;
      rraData <= 8'h00;
      rraWr <= 1'b0;
      tunPend <= 1'b0;
    end else begin
      // Pulse outputs default low
      dozeLoad <= 1'b0;
      wakeLoad <= 1'b0;
      lnkSend <= 1'b0;
      tempStart <= 1'b0;
      compStart <= 1'b0;
      linkRestart <= 1'b0;
      tunnelGo <= 1'b0;
      remoteDone <= 1'b0;
      // Partner read of a scratch register raises the read event
      scratchRead <= prtReq & ~prtWe & (prtAddr[7:3] == 5'h00);
      // Requests are latched in any state but S_OFF; a pending remote access is dropped on link loss or wake timeout
      if (rraGo) begin
        remotePending <= 1'b1;
        rraAddr <= wb_dat_i[7:0];
        rraData <= wb_dat_i[15:8];
        rraWr <= wb_dat_i[`PLPM_RACC_WR];
      end
      if (tunGo && state != S_OFF)
        tunPend <= 1'b1;
      case (state)
        S_OFF: begin
          txRxEn <= 1'b0;
          if (pairDone) begin
            pairUp <= 1'b1;
            txRxEn <= 1'b1;
            hkDone <= 4'h0;
            state <= S_HOUSE;
          end
        end
        S_HOUSE: begin
          if (isRemote) begin
            // Remote follows the Local one's sleep command
            dozeLoad <= 1'b1;
            state <= S_DOZE;
          end else if (remotePending) begin
            phase <= P_RRA;
            lnkSend <= 1'b1;
            lnkOp <= rraWr ? `PLPM_OP_WR : `PLPM_OP_RD;
            lnkAddr <= rraAddr;
            lnkData <= rraWr ? rraData : 8'h00;
            state <= S_WAIT;
          end else if (ctrl[`PLPM_CTRL_TEMP] && !hkDone[0]) begin
            tempStart <= 1'b1;
            state <= S_TEMP;
          end else if (ctrl[`PLPM_CTRL_COMP] && !hkDone[1]) begin
            compStart <= 1'b1;
            state <= S_COMP;
          end else if (!hkDone[2]) begin
            phase <= P_PWR;
            lnkSend <= 1'b1;
            lnkOp <= `PLPM_OP_WR;
            lnkAddr <= `PLPM_RA_PWR;
            lnkData <= ctrl;
            state <= S_WAIT;
          end else if (!hkDone[3]) begin
            phase <= P_DZ;
            lnkSend <= 1'b1;
            lnkOp <= `PLPM_OP_WR;
            lnkAddr <= `PLPM_RA_DOZE;
            lnkData <= dozeUnits;
            state <= S_WAIT;
          end else if (tunPend) begin
            phase <= P_TUN;
            lnkSend <= 1'b1;
            lnkOp <= `PLPM_OP_TUNNEL;
            state <= S_WAIT;
          end else if (ctrl[`PLPM_CTRL_SLEEP]) begin
            phase <= P_SLP;
            lnkSend <= 1'b1;
            lnkOp <= `PLPM_OP_SLEEP;
            state <= S_WAIT;
          end else begin
            // Idle interval with circuits kept on
            dozeLoad <= 1'b1;
            state <= S_DOZE;
          end
        end
        S_TEMP: if (tempDone) begin
          hkDone[0] <= 1'b1;
          state <= S_HOUSE;
        end
        S_COMP: if (compDone) begin
          hkDone[1] <= 1'b1;
          state <= S_HOUSE;
        end
        S_WAIT: begin
          if (lnkLost) begin
            // Channel gone mid-access
            pairUp <= 1'b0;
            linkRestart <= 1'b1;
            // A request taken in this very cycle still stands
            remotePending <= rraGo;
            state <= S_OFF;
          end else if (lnkAck) begin
            state <= S_HOUSE;
            case (phase)
              P_RRA: begin
                remotePending <= 1'b0;
                remoteDone <= 1'b1;
                if (!rraWr) begin
                  rraData <= lnkRxData;
                  if (!ctrl[`PLPM_CTRL_RDMASK])
                    scratchRead <= 1'b1;
                end
              end
              P_PWR: hkDone[2] <= 1'b1;
              P_DZ: hkDone[3] <= 1'b1;
              P_TUN: begin
                // A new command in the same cycle wins
                tunPend <= tunGo;
                tunnelGo <= 1'b1;
                remoteDone <= 1'b1;
              end
              P_SLP: begin
                // New request raced the ack: stay awake
                if (!remotePending && !tunPend && !rraGo && !tunGo) begin
                  sleeping <= 1'b1;
                  analogOn <= 1'b0;
                  lpClkOn <= 1'b0;
                  txRxEn <= 1'b0;
                  dozeLoad <= 1'b1;
                  state <= S_DOZE;
                end
              end
              default: state <= S_HOUSE;
            endcase
          end
        end
        S_DOZE: begin
          if (isRemote && lnkSleepCmd && !sleeping) begin
            sleeping <= 1'b1;
            analogOn <= 1'b0;
            lpClkOn <= 1'b0;
            txRxEn <= 1'b0;
            dozeLoad <= 1'b1;
          end else if (dozeExp) begin
            // Wake alone, power up, seek partner
            sleeping <= 1'b0;
            analogOn <= 1'b1;
            lpClkOn <= 1'b1;
            txRxEn <= 1'b1;
            wakeLoad <= 1'b1;
            state <= S_WAKE;
          end
        end
        S_WAKE: begin
          if (wakeExp) begin
            pairUp <= 1'b0;
            linkRestart <= 1'b1;
            remotePending <= rraGo;
            state <= S_OFF;
          end else if (lnkAck) begin
            hkDone <= 4'h0;
            state <= S_HOUSE;
          end else if (unitTick && !isRemote) begin
            lnkSend <= 1'b1;
            lnkOp <= `PLPM_OP_PING;
          end
        end
        default: state <= S_OFF;
      endcase
    end
  end
endmodule // plpm_manager
`default_nettype wire

// ---- verilog/plpm_map.vh ----
`ifndef PLPM_MAP_VH
`define PLPM_MAP_VH
// ***********************************************
// Register byte offsets
// ***********************************************
`define PLPM_OFF_CTRL     8'h00
`define PLPM_OFF_RACC     8'h04
`define PLPM_OFF_DOZE     8'h08
`define PLPM_OFF_WAKE     8'h0C
`define PLPM_OFF_STAT     8'h10
`define PLPM_OFF_SCR      8'h20
// ***********************************************
// Control register fields
// ***********************************************
`define PLPM_CTRL_SLEEP   0
`define PLPM_CTRL_ROLE    1
`define PLPM_CTRL_TEMP    2
`define PLPM_CTRL_COMP    3
`define PLPM_CTRL_RDMASK  4
`define PLPM_CTRL_TUNNEL  5
`define PLPM_CTRL_RST     8'h01
// ***********************************************
// Remote access register fields
// ***********************************************
`define PLPM_RACC_WR      16
`define PLPM_RACC_BUSY    8
// ***********************************************
// Timing: timers count in units of 10 ms
// ***********************************************
`define PLPM_UNIT_MS      10
`define PLPM_CLK_KHZ      100000
`define PLPM_UNIT_CYC     (`PLPM_CLK_KHZ * `PLPM_UNIT_MS)
`define PLPM_DOZE_MS      110
`define PLPM_WAKE_MS      250
// Sized so the 8-bit unit registers take them whole
`define PLPM_DOZE_RST     8'h0B
`define PLPM_WAKE_RST     8'h19
// ***********************************************
// Link frame opcodes
// ***********************************************
`define PLPM_OP_WR        3'h1
`define PLPM_OP_RD        3'h2
`define PLPM_OP_SLEEP     3'h3
`define PLPM_OP_PING      3'h4
`define PLPM_OP_TUNNEL    3'h5
// ***********************************************
// Partner-side register addresses
// ***********************************************
`define PLPM_RA_SCR       8'h00
`define PLPM_RA_PWR       8'h10
`define PLPM_RA_DOZE      8'h11
`define PLPM_RA_LOCAL     8'h80
`define PLPM_RA_POISON    8'hFF
`endif

// ---- verilog/plpm_unit_timer.v ----
`timescale 1ns/1ps
`default_nettype none
// ***********************************************
// Down-counter in coarse time units
// ***********************************************
module plpm_unit_timer (
  input  wire       clk_sys, // System clock
  input  wire       rst,     // Async reset, high
  input  wire       tick,    // One pulse per time unit
  input  wire       load,    // Start or restart the count
  input  wire [7:0] period,  // Units to run
  output reg        expired  // One-cycle pulse at the end
);
  reg [7:0] cnt; // Units left
  reg       run; // Counting
  // ***********************************************
  // Count units, pulse when the last one passes
  // ***********************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt     <= 8'h00;
      run     <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        // Zero period treated as one unit, never hangs
        cnt <= (period == 8'h00) ? 8'h01 : period;
        run <= 1'b1;
      end else if (run && tick) begin
        if (cnt <= 8'h01) begin
          run     <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
endmodule // plpm_unit_timer
`default_nettype wire
